// ---- hw/anps_pkg.sv ----
// constants, layouts and carrier types for the next-page status register bank
package anps_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] ANPS_IDX_EXP = 6'h06;
	localparam logic [5:0] ANPS_IDX_NPT = 6'h07;
	localparam logic [5:0] ANPS_IDX_NPR = 6'h08;
	localparam logic [5:0] ANPS_IDX_MSS = 6'h0a;
	localparam logic [5:0] ANPS_IDX_IST = 6'h18;
	localparam logic [5:0] ANPS_IDX_IMSK = 6'h19;
	// expansion register bit positions
	localparam int ANPS_EXP_PDF = 4;
	localparam int ANPS_EXP_LPNP = 3;
	localparam int ANPS_EXP_LNP = 2;
	localparam int ANPS_EXP_PGR = 1;
	localparam int ANPS_EXP_LPAN = 0;
	// master/slave status bit positions
	localparam int ANPS_MSS_FLT = 15;
	localparam int ANPS_MSS_ROLE = 14;
	localparam int ANPS_MSS_LRX = 13;
	localparam int ANPS_MSS_RRX = 12;
	localparam int ANPS_MSS_GFD = 11;
	localparam int ANPS_MSS_GHD = 10;
	// interrupt status bit positions and width
	localparam int ANPS_IRQ_PDF = 0;
	localparam int ANPS_IRQ_PGR = 1;
	localparam int ANPS_IRQ_MSF = 2;
	localparam int ANPS_IRQ_IDLE = 3;
	localparam int ANPS_IRQ_W = 4;
	// reset values and idle counter ceiling
	localparam logic [10:0] ANPS_NPT_CODE_RST = 11'h001;
	localparam logic [10:0] ANPS_NPR_CODE_RST = 11'h000;
	localparam logic [7:0] ANPS_IDLE_MAX = 8'hff;
	localparam logic [7:0] ANPS_IDLE_RST = 8'h00;
	// one next page code word, transmit and receive share the layout
	typedef struct packed {
		logic more;
		logic rsvd;
		logic msg;
		logic page_comply_ack;
		logic toggle;
		logic [10:0] code;
	} anps_page_s;
	// reset page images
	localparam anps_page_s ANPS_NPT_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ANPS_NPT_CODE_RST};
	localparam anps_page_s ANPS_NPR_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ANPS_NPR_CODE_RST};
endpackage

// ---- hw/anps_regs.sv ----
// wishbone register bank for auto-negotiation expansion, next pages and master/slave status
`timescale 1ns/1ps
`default_nettype none

module anps_regs import anps_pkg::*; #(
	parameter bit LOCAL_NP_ABLE = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// auto-negotiation side, same clock
	input wire logic an_enable_i,
	input wire logic partner_autoneg_able_i,
	input wire logic partner_np_able_i,
	input wire logic pd_fault_i,
	input wire logic page_rx_i,
	input wire anps_page_s page_rx_data_i,
	input wire logic page_tx_done_i,
	// master/slave side, same clock
	input wire logic ms_fault_i,
	input wire logic ms_master_i,
	input wire logic local_rx_ok_i,
	input wire logic remote_rx_ok_i,
	input wire logic gig_fd_adv_i,
	input wire logic partner_gig_hd_i,
	input wire logic idle_err_i,
	// page to transmit and interrupt
	output anps_page_s tx_page_o,
	output logic irq_o
);

	// bus decode
	logic req; // request present and not yet answered
	logic [5:0] idx; // word index
	logic rd_exp; // expansion read taken this edge
	logic rd_mss; // master/slave read taken this edge
	logic wr_npt; // transmit page write
	logic wr_ist; // interrupt status write
	logic wr_imsk; // interrupt mask write

	// stored state
	logic pd_fault_r; // parallel detect fault latch
	logic page_rcvd_r; // new page latch
	logic ms_fault_r; // master/slave fault latch
	logic [7:0] idle_cnt_r; // idle error counter
	logic [7:0] idle_cnt_nxt;
	anps_page_s rx_page_r; // last page from the partner
	logic [ANPS_IRQ_W-1:0] ist_r; // sticky interrupt status
	logic [ANPS_IRQ_W-1:0] ist_nxt;
	logic [ANPS_IRQ_W-1:0] imsk_r; // interrupt mask
	logic [ANPS_IRQ_W-1:0] ev; // events this cycle
	logic [15:0] rdata; // read mux
	logic [15:0] exp_v; // expansion image
	logic [15:0] mss_v; // master/slave image

	// a request is answered one edge after it is seen
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign idx = wb_adr_i[7:2];
	assign rd_exp = req && !wb_we_i && (idx == ANPS_IDX_EXP);
	assign rd_mss = req && !wb_we_i && (idx == ANPS_IDX_MSS);
	assign wr_npt = req && wb_we_i && (idx == ANPS_IDX_NPT);
	assign wr_ist = req && wb_we_i && (idx == ANPS_IDX_IST);
	assign wr_imsk = req && wb_we_i && (idx == ANPS_IDX_IMSK);

	// ack pulse, one cycle per request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// parallel detect fault: set wins over the clearing read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pd_fault_r <= 1'b0;
		end else begin
			pd_fault_r <= pd_fault_i || (pd_fault_r && !rd_exp);
		end
	end

	// new page flag: set wins over the clearing read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			page_rcvd_r <= 1'b0;
		end else begin
			page_rcvd_r <= page_rx_i || (page_rcvd_r && !rd_exp);
		end
	end

	// partner page capture; reserved bit forced to zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_page_r <= ANPS_NPR_RST;
		end else if (page_rx_i) begin
			rx_page_r <= page_rx_data_i;
			rx_page_r.rsvd <= 1'b0;
		end
	end

	// transmit page: software fields by byte lane
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_page_o.code <= ANPS_NPT_CODE_RST;
			tx_page_o.more <= 1'b0;
			tx_page_o.msg <= 1'b0;
			tx_page_o.page_comply_ack <= 1'b0;
		end else if (wr_npt) begin
			// low lane holds code bits 7:0
			if (wb_sel_i[0]) begin
				tx_page_o.code[7:0] <= wb_dat_i[7:0];
			end
			// high lane holds flags and code bits 10:8
			if (wb_sel_i[1]) begin
				tx_page_o.code[10:8] <= wb_dat_i[10:8];
				tx_page_o.more <= wb_dat_i[15];
				tx_page_o.msg <= wb_dat_i[13];
				tx_page_o.page_comply_ack <= wb_dat_i[12];
			end
		end
	end

	// reserved bit of the transmit page never set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_page_o.rsvd <= 1'b0;
		end else begin
			tx_page_o.rsvd <= 1'b0;
		end
	end

	// toggle flips after each exchanged code word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_page_o.toggle <= 1'b0;
		end else if (page_tx_done_i) begin
			tx_page_o.toggle <= !tx_page_o.toggle;
		end
	end

	// master/slave fault: set wins over the clearing read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ms_fault_r <= 1'b0;
		end else begin
			ms_fault_r <= ms_fault_i || (ms_fault_r && !rd_mss);
		end
	end

	// idle error counter next value
	always_comb begin
		if (rd_mss) begin
			// restart; an error in the read cycle counts as one
			idle_cnt_nxt = idle_err_i ? 8'h01 : ANPS_IDLE_RST;
		end else if (idle_err_i && (idle_cnt_r != ANPS_IDLE_MAX)) begin
			idle_cnt_nxt = idle_cnt_r + 8'h01;
		end else begin
			// hold, including at the ceiling
			idle_cnt_nxt = idle_cnt_r;
		end
	end

	// idle error counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_cnt_r <= ANPS_IDLE_RST;
		end else begin
			idle_cnt_r <= idle_cnt_nxt;
		end
	end

	// event vector for the interrupt status
	always_comb begin
		ev = '0;
		ev[ANPS_IRQ_PDF] = pd_fault_i;
		ev[ANPS_IRQ_PGR] = page_rx_i;
		ev[ANPS_IRQ_MSF] = ms_fault_i;
		ev[ANPS_IRQ_IDLE] = idle_err_i && (idle_cnt_r == ANPS_IDLE_MAX) && !rd_mss;
	end

	// sticky status: write one clears, event wins
	always_comb begin
		ist_nxt = ist_r;
		if (wr_ist && wb_sel_i[0]) begin
			ist_nxt = ist_r & ~wb_dat_i[ANPS_IRQ_W-1:0];
		end
		ist_nxt = ist_nxt | ev;
	end

	// status and mask registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ist_r <= '0;
			imsk_r <= '0;
		end else begin
			ist_r <= ist_nxt;
			if (wr_imsk && wb_sel_i[0]) begin
				imsk_r <= wb_dat_i[ANPS_IRQ_W-1:0];
			end
		end
	end

	// level interrupt, registered from next status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(ist_nxt & (wr_imsk && wb_sel_i[0] ? wb_dat_i[ANPS_IRQ_W-1:0] : imsk_r));
		end
	end

	// expansion image; reserved bits zero
	always_comb begin
		exp_v = 16'h0000;
		exp_v[ANPS_EXP_PDF] = pd_fault_r;
		exp_v[ANPS_EXP_LPNP] = partner_np_able_i;
		exp_v[ANPS_EXP_LNP] = LOCAL_NP_ABLE;
		exp_v[ANPS_EXP_PGR] = page_rcvd_r;
		exp_v[ANPS_EXP_LPAN] = an_enable_i && partner_autoneg_able_i;
	end

	// master/slave image; bits 9:8 zero
	always_comb begin
		mss_v = 16'h0000;
		mss_v[ANPS_MSS_FLT] = ms_fault_r;
		mss_v[ANPS_MSS_ROLE] = ms_master_i;
		mss_v[ANPS_MSS_LRX] = local_rx_ok_i;
		mss_v[ANPS_MSS_RRX] = remote_rx_ok_i;
		mss_v[ANPS_MSS_GFD] = gig_fd_adv_i;
		mss_v[ANPS_MSS_GHD] = partner_gig_hd_i;
		mss_v[7:0] = idle_cnt_r;
	end

	// read mux; unmapped reads return zero
	always_comb begin
		case (idx)
			ANPS_IDX_EXP: begin
				rdata = exp_v;
			end
			ANPS_IDX_NPT: begin
				rdata = tx_page_o;
			end
			ANPS_IDX_NPR: begin
				rdata = rx_page_r;
			end
			ANPS_IDX_MSS: begin
				rdata = mss_v;
			end
			ANPS_IDX_IST: begin
				rdata = {12'h000, ist_r};
			end
			ANPS_IDX_IMSK: begin
				rdata = {12'h000, imsk_r};
			end
			default: begin
				rdata = 16'h0000;
			end
		endcase
	end

	// read data captured with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req && !wb_we_i) begin
			wb_dat_o <= {16'h0000, rdata};
		end
	end

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_PDF_SET: assert property (pd_fault_i |=> pd_fault_r)
		else $error("fault event not latched");
	AST_PDF_CLR: assert property (rd_exp && !pd_fault_i |=> !pd_fault_r && wb_ack_o)
		else $error("fault flag not cleared by read");
	AST_LPNP_RD: assert property (rd_exp |=> wb_dat_o[ANPS_EXP_LPNP] == $past(partner_np_able_i))
		else $error("partner next page ability misreported");
	AST_LNP_RD: assert property (rd_exp |=> wb_dat_o[ANPS_EXP_LNP] == LOCAL_NP_ABLE)
		else $error("local next page ability misreported");
	AST_PAGE_RX: assert property (page_rx_i |=> page_rcvd_r && rx_page_r.code == $past(page_rx_data_i.code))
		else $error("received page not captured");
	AST_LPAN_RD: assert property (rd_exp |=> wb_dat_o[ANPS_EXP_LPAN] == $past(an_enable_i && partner_autoneg_able_i))
		else $error("partner autoneg ability misreported");
	AST_TOGGLE: assert property (page_tx_done_i |=> tx_page_o.toggle != $past(tx_page_o.toggle))
		else $error("toggle did not invert");
	AST_RST_CODE: assert property ($past(rst_i) |-> tx_page_o.code == ANPS_NPT_CODE_RST && rx_page_r.rsvd == 1'b0)
		else $error("reset code field wrong");
	AST_MSF_SET: assert property (ms_fault_i |=> ms_fault_r ##1 (ms_fault_r || $past(rd_mss)))
		else $error("master slave fault lost");
	AST_IDLE_RESTART: assert property (rd_mss |=> idle_cnt_r == {7'h00, $past(idle_err_i)})
		else $error("idle count not restarted by read");
	AST_IDLE_SAT: assert property (idle_cnt_r == ANPS_IDLE_MAX && !rd_mss |=> idle_cnt_r == ANPS_IDLE_MAX)
		else $error("idle count wrapped");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held more than one cycle");

endmodule // anps_regs

`default_nettype wire

// ---- tb/anps_partner.sv ----
// link partner model: sends one next page per request and reports the exchange
`timescale 1ns/1ps
`default_nettype none
module anps_partner import anps_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i, // request one page exchange
	input wire anps_page_s page_i, // page content to send
	output logic page_rx_o, // page arrival strobe
	output anps_page_s page_rx_data_o, // page word, churns between pages
	output logic tx_done_o // local code word exchanged
);
	// one page per request; page word churns while no page is offered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			page_rx_o <= 1'b0;
			tx_done_o <= 1'b0;
			page_rx_data_o <= '0;
		end else begin
			page_rx_o <= go_i;
			tx_done_o <= go_i;
			if (go_i) begin
				page_rx_data_o <= page_i;
				page_rx_data_o.rsvd <= 1'b0;
			end else begin
				page_rx_data_o <= ~page_rx_data_o;
			end
		end
	end
endmodule // anps_partner
`default_nettype wire

// ---- tb/anps_regs_test.sv ----
// self-checking bench for the next-page status register bank
`timescale 1ns/1ps
`default_nettype none
module anps_regs_test import anps_pkg::*;;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0; // clock, reset, bus request
	logic [7:0] adr = '0; // byte address
	logic [3:0] sel = '0; // byte enables
	logic [31:0] wdat = '0, rdat; // bus data
	logic ack, irq, go = 0, prx, pdone; // handshake, interrupt, partner strobes
	logic [7:0] lv = '0; // side status levels
	logic [2:0] ev = '0; // pd fault, ms fault, idle error pulses
	anps_page_s pg = '0, prd, txp; // page to send, received page, transmit page
	int mismatches = 0, n_checks = 0, cycles = 0; // tallies
	bit pdf, pgr, msf, tog; // model flags
	int cnt, ist, msk, npt, npr; // model registers
	logic [7:0] regs [7] = '{8'h18, 8'h1c, 8'h20, 8'h28, 8'h60, 8'h64, 8'h2c}; // read sweep
	// 50 MHz clock
	always #10 clk_i = ~clk_i;
	anps_regs anps_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .an_enable_i(lv[0]),
		.partner_autoneg_able_i(lv[1]), .partner_np_able_i(lv[2]), .pd_fault_i(ev[0]), .page_rx_i(prx),
		.page_rx_data_i(prd), .page_tx_done_i(pdone), .ms_fault_i(ev[1]), .ms_master_i(lv[3]),
		.local_rx_ok_i(lv[4]), .remote_rx_ok_i(lv[5]), .gig_fd_adv_i(lv[6]), .partner_gig_hd_i(lv[7]),
		.idle_err_i(ev[2]), .tx_page_o(txp), .irq_o(irq));
	anps_partner anps_partner_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .page_i(pg), .page_rx_o(prx),
		.page_rx_data_o(prd), .tx_done_o(pdone));
	// compare and tally
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// verdict and end of run
	task automatic summarize();
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end
	// expected read image from the model
	function automatic logic [31:0] img(input logic [7:0] a);
		case (a)
			8'h18: return {pdf, lv[2], 1'b1, pgr, lv[0] & lv[1]};
			8'h1c: return npt | tog << 11;
			8'h20: return npr;
			8'h28: return {msf, lv[3], lv[4], lv[5], lv[6], lv[7], 2'b00, cnt[7:0]};
			8'h60: return ist;
			8'h64: return msk;
			default: return 0;
		endcase
	endfunction
	// one classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
	endtask
	// read and compare, then apply clear-on-read to the model
	task automatic rd(input logic [7:0] a);
		logic [31:0] q, e;
		e = img(a);
		bus(0, a, 4'h3, 0, q);
		chk(q, e);
		if (a == 8'h18) {pdf, pgr} = 0;
		if (a == 8'h28) {msf, cnt} = 0;
	endtask
	// write and mirror in the model
	task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		logic [31:0] q;
		bus(1, a, s, d, q);
		if (a == 8'h1c && s[0]) npt = npt & 'hff00 | d & 'hff;
		if (a == 8'h1c && s[1]) npt = npt & 'hff | d & 'hb700;
		if (a == 8'h60 && s[0]) ist = ist & ~d;
		if (a == 8'h64 && s[0]) msk = d & 'hf;
	endtask
	// side event pulses and one optional page exchange
	task automatic fire(input logic [2:0] v, input logic g);
		@(posedge clk_i);
		ev <= v;
		go <= g;
		pg <= anps_page_s'(16'($urandom));
		@(posedge clk_i);
		ev <= 0;
		go <= 0;
		if (v[0]) {pdf, ist[0]} = 2'b11;
		if (v[1]) {msf, ist[2]} = 2'b11;
		if (v[2] && cnt == 255) ist[3] = 1;
		else if (v[2]) cnt++;
		if (g) {pgr, ist[1]} = 2'b11;
		if (g) tog ^= 1;
		if (g) npr = pg & 'hbfff;
	endtask
	// random levels, events, writes and a full read sweep
	task automatic round();
		@(posedge clk_i);
		lv <= 8'($urandom);
		repeat ($urandom % 4) fire(3'($urandom), 1'($urandom));
		wr(8'h1c, 4'($urandom), $urandom);
		wr(8'h20, 4'h3, $urandom);
		wr(8'h2c, 4'h3, $urandom);
		wr(8'h64, 4'h1, $urandom);
		wr(8'h60, 4'h1, $urandom);
		foreach (regs[i]) rd(regs[i]);
		chk(irq, |(ist & msk));
		chk(txp, npt | tog << 11);
	endtask
	// main sequence
	initial begin
		void'($urandom(32'h980cfda7));
		npt = 1;
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		chk(txp, 'h1);
		foreach (regs[i]) rd(regs[i]);
		repeat (300) fire(3'b100, 0);
		rd(8'h28);
		rd(8'h28);
		rd(8'h60);
		repeat (40) round();
		summarize();
	end
endmodule // anps_regs_test
`default_nettype wire
